/* File: shared/cluster_map.svh */
`ifndef CLUSTER_MAP_SVH
`define CLUSTER_MAP_SVH
// How it works
// - each cell takes four data bits, a carry in and a chain in.
// - normal mode feeds the four inputs into a sixteen-entry lookup table.
// - one table input selects carry in or the fourth data bit.
// - normal mode allows packing and register feedback into the table.
// - arithmetic mode adds two bits with carry in, carry out to next cell.
// - arithmetic cells output registered and unregistered results, keep packing, feedback.
// - carry leaves cell sixteen toward the next cluster in the column.
// - eight controls exist; at most seven may be in use together.
// - using synchronous load makes the first clock gate unusable.
// - register packing and synchronous load never coexist in a cluster.
// - at most four controls may come from the local interconnect.
// - synchronous clear and load reach every register on its clock event.
// - each cluster clock is paired with its own clock gate.
// - both edges of one clock use both cluster clocks, opposite polarity.
// - a low clock gate stops its clock; registers hold.
// - controls come from six row clock lines or local interconnect.
// - no preset input; preset means storing inverted around the clear.
// - optional active-low chip-wide clear overrides every other control.
// - register chain feeds each register from the previous cell's register; the first cell's chain input is zero.
// - each register works as D, T, JK or SR element.
// ****************************************
// bus map (byte addresses)
// ****************************************
`define SRC_OFS   7'h00
`define STAT_OFS  7'h04
`define STATE_OFS 7'h08
`define CELL_BIT  6
// ****************************************
// source register fields
// ****************************************
`define SEL_W     3
`define SEL_LOCAL 3'h6
`define SEL_OFF   3'h7
`define SRC_POL1  24
`define SRC_POL2  25
`define SRC_RST   26'h0FFFFFF
// ****************************************
// cell config fields
// ****************************************
`define C_ARITH   16
`define C_CSEL    17
`define C_CLK     18
`define C_ACSEL   19
`define C_ACEN    20
`define C_PRESET  21
`define C_CHAIN   22
`define C_PACK    23
`define C_FDBK    24
`define C_STORE   25
`define CELL_RST  27'h0000000
// ****************************************
// status fields
// ****************************************
`define ST_MANY   0
`define ST_LOCAL  1
`define ST_GATE1  2
`define ST_PACK   3
`define ST_CNT    8
`define ST_LCNT   12
`define MAX_ON    4'h7
`define MAX_LOCAL 4'h4
`endif

/* File: shared/cluster_pkg.sv */
package cluster_pkg;
  typedef enum logic [1:0] {
    ST_D  = 2'b00,
    ST_T  = 2'b01,
    ST_JK = 2'b10,
    ST_SR = 2'b11
  } store_e;
  typedef enum logic [2:0] {
    CTL_CLK1  = 3'h0,
    CTL_CLK2  = 3'h1,
    CTL_GATE1 = 3'h2,
    CTL_GATE2 = 3'h3,
    CTL_ACLR1 = 3'h4,
    CTL_ACLR2 = 3'h5,
    CTL_SCLR  = 3'h6,
    CTL_SLOAD = 3'h7
  } ctl_e;
  typedef logic [26:0] cell_cfg_t;
  typedef logic [25:0] src_cfg_t;
endpackage : cluster_pkg

/* File: shared/cluster_ctrl_if.sv */
`timescale 1ns/10ps
interface cluster_ctrl_if;
  logic tick1;
  logic tick2;
  logic aclr1;
  logic aclr2;
  logic sclr;
  logic sload;
  logic chip_clr;
  modport drive (output tick1, tick2, aclr1, aclr2, sclr, sload, chip_clr);
  modport take  (input  tick1, tick2, aclr1, aclr2, sclr, sload, chip_clr);
endinterface : cluster_ctrl_if

/* File: core/logic_cell_slice.sv */
`timescale 1ns/10ps
`include "cluster_map.svh"
module logic_cell_slice (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_ce,
  cluster_ctrl_if.take               ctl,
  input  wire cluster_pkg::cell_cfg_t i_cfg,
  input  wire logic [3:0]            i_data,
  input  wire logic                  i_carry,
  input  wire logic                  i_chain,
  output logic                       o_comb,
  output logic                       o_reg,
  output logic                       o_carry
);
  logic                q_q;
  logic                clr;
  logic                val;
  logic                a;
  logic                lut_fourth_input;
  logic [3:0]          idx;
  logic                res;
  logic                din;
  logic                nv;
  logic                tick;
  logic                pre;
  cluster_pkg::store_e st;

  assign pre = i_cfg[`C_PRESET];
  assign st  = cluster_pkg::store_e'(i_cfg[`C_STORE+1:`C_STORE]);
  assign clr = ctl.chip_clr | (i_cfg[`C_ACEN] &
               (i_cfg[`C_ACSEL] ? ctl.aclr2 : ctl.aclr1));
  assign val = (q_q & ~clr) ^ pre;
  assign a   = i_cfg[`C_FDBK] ? val : i_data[0];
  assign lut_fourth_input = i_cfg[`C_CSEL] ? i_carry : i_data[3];
  assign idx = i_cfg[`C_ARITH] ? {i_data[2], i_carry, i_data[1], a}
                               : {lut_fourth_input, i_data[2], i_data[1], a};
  assign res = i_cfg[idx];
  assign o_carry = i_cfg[`C_ARITH] ? ((a & i_data[1]) | (i_carry & (a ^ i_data[1])))
                                   : i_carry;
  assign din = i_cfg[`C_CHAIN] ? i_chain : (i_cfg[`C_PACK] ? i_data[3] : res);
  assign tick = i_cfg[`C_CLK] ? ctl.tick2 : ctl.tick1;

  // ****************************************
  // storage element
  // ****************************************
  always_comb begin
    unique case (st)
      cluster_pkg::ST_D:  nv = din;
      cluster_pkg::ST_T:  nv = val ^ din;
      cluster_pkg::ST_JK: nv = (din & ~val) | (~i_data[3] & val);
      cluster_pkg::ST_SR: nv = din | (val & ~i_data[3]);
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q_q <= 1'b0;
    end else if (i_ce) begin
      if (clr) begin
        q_q <= 1'b0;
      end else if (tick) begin
        if (ctl.sclr) begin
          q_q <= pre;
        end else if (ctl.sload) begin
          q_q <= i_data[3] ^ pre;
        end else begin
          q_q <= nv ^ pre;
        end
      end
    end
  end

  assign o_comb = res;
  assign o_reg  = val;

  aclr_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    clr && i_ce |=> q_q == 1'b0) else $error("cleared register not at clear value");
  sclr_hit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && tick && ctl.sclr && !clr ##1 !clr |-> o_reg == 1'b0)
    else $error("sync clear missed");
  gate_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !tick && !clr ##1 !clr |-> q_q == $past(q_q))
    else $error("register moved without clock event");
endmodule : logic_cell_slice

/* File: core/logic_cluster_core.sv */
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "cluster_map.svh"
module logic_cluster_core #(
  parameter bit CHIP_CLEAR_EN = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic [6:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [5:0]  i_row_clk,
  input  wire logic [7:0]  i_local_ctrl,
  input  wire logic [63:0] i_cell_data,
  input  wire logic        i_carry_in,
  input  wire logic        i_chip_wide_clear_n,
  output logic      [15:0] o_comb,
  output logic      [15:0] o_reg,
  output logic             o_carry_out
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] sel_of(input cluster_pkg::src_cfg_t s,
                                        input cluster_pkg::ctl_e k);
    sel_of = s[int'(k)*3 +: 3];
  endfunction : sel_of

  function automatic logic [3:0] count_sel(input cluster_pkg::src_cfg_t s,
                                           input bit local_only);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      if (local_only ? (s[k*3 +: 3] == `SEL_LOCAL) : (s[k*3 +: 3] != `SEL_OFF)) begin
        n = n + 4'h1;
      end
    end
    count_sel = n;
  endfunction : count_sel

  function automatic logic used(input cluster_pkg::src_cfg_t s,
                                input cluster_pkg::ctl_e k);
    used = sel_of(s, k) != `SEL_OFF;
  endfunction : used

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // ****************************************
  // bus slave
  // ****************************************
  cluster_pkg::src_cfg_t  src_q;
  cluster_pkg::cell_cfg_t cfg_q [16];
  logic [3:0]             err_q;
  logic                   ack_q;
  logic                   req;
  logic                   wr_go;
  logic                   cell_hit;
  logic [3:0]             cell_idx;
  logic [31:0]            src_new;
  logic [31:0]            cell_new;
  logic [3:0]             err_set;
  logic                   src_ok;
  logic                   any_pack;
  logic                   sload_on;
  logic [3:0]             n_on;
  logic [3:0]             n_local;

  assign req      = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~(ack_q & i_ce);
  assign wr_go    = i_avs_write & ack_q & i_ce;
  assign cell_hit = i_avs_address[`CELL_BIT];
  assign cell_idx = i_avs_address[5:2];
  assign src_new  = merge({6'h00, src_q}, i_avs_writedata, i_avs_byteenable);
  assign cell_new = merge({5'h00, cfg_q[cell_idx]}, i_avs_writedata, i_avs_byteenable);
  assign sload_on = used(src_q, cluster_pkg::CTL_SLOAD);
  assign n_on     = count_sel(src_q, 1'b0);
  assign n_local  = count_sel(src_q, 1'b1);

  always_comb begin
    any_pack = 1'b0;
    for (int i = 0; i < 16; i++) begin
      any_pack = any_pack | cfg_q[i][`C_PACK];
    end
  end

  // refuse a source setup that breaks the cluster limits
  always_comb begin
    err_set = 4'h0;
    src_ok  = 1'b0;
    if (wr_go && !cell_hit && i_avs_address[5:2] == 4'(`SRC_OFS >> 2)) begin
      err_set[`ST_MANY]  = count_sel(src_new[25:0], 1'b0) > `MAX_ON;
      err_set[`ST_LOCAL] = count_sel(src_new[25:0], 1'b1) > `MAX_LOCAL;
      err_set[`ST_GATE1] = used(src_new[25:0], cluster_pkg::CTL_SLOAD) &&
                           used(src_new[25:0], cluster_pkg::CTL_GATE1);
      err_set[`ST_PACK]  = used(src_new[25:0], cluster_pkg::CTL_SLOAD) && any_pack;
      src_ok = err_set == 4'h0;
    end else if (wr_go && cell_hit) begin
      err_set[`ST_PACK] = cell_new[`C_PACK] && sload_on;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      src_q <= `SRC_RST;
    end else if (i_ce && src_ok) begin
      src_q <= src_new[25:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < 16; i++) begin
        cfg_q[i] <= `CELL_RST;
      end
    end else if (i_ce && wr_go && cell_hit && !err_set[`ST_PACK]) begin
      cfg_q[cell_idx] <= cell_new[26:0];
    end
  end

  // sticky errors, write one to clear; a new error wins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      err_q <= 4'h0;
    end else if (i_ce) begin
      if (wr_go && !cell_hit && i_avs_address[5:2] == 4'(`STAT_OFS >> 2)) begin
        err_q <= (err_q & ~(i_avs_writedata[3:0] & {4{i_avs_byteenable[0]}})) | err_set;
      end else begin
        err_q <= err_q | err_set;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_ce && i_avs_read && !ack_q) begin
      if (cell_hit) begin
        o_avs_readdata <= {5'h00, cfg_q[cell_idx]};
      end else begin
        unique case (i_avs_address[5:2])
          4'(`SRC_OFS >> 2):   o_avs_readdata <= {6'h00, src_q};
          4'(`STAT_OFS >> 2):  o_avs_readdata <= {16'h0000, n_local, n_on, 4'h0, err_q};
          4'(`STATE_OFS >> 2): o_avs_readdata <= {15'h0000, o_carry_out, o_reg};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // control generation
  // ****************************************
  logic [7:0] lvl;
  logic       c1_prev_q;
  logic       c2_prev_q;
  logic       edge1;
  logic       edge2;
  logic       gate1_eff;
  logic       gate2_eff;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      unique case (src_q[k*3 +: 3])
        `SEL_LOCAL: lvl[k] = i_local_ctrl[k];
        `SEL_OFF:   lvl[k] = 1'b0;
        default:    lvl[k] = i_row_clk[src_q[k*3 +: 3]];
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      c1_prev_q <= 1'b0;
      c2_prev_q <= 1'b0;
    end else if (i_ce) begin
      c1_prev_q <= lvl[cluster_pkg::CTL_CLK1];
      c2_prev_q <= lvl[cluster_pkg::CTL_CLK2];
    end
  end

  assign edge1 = src_q[`SRC_POL1] ? (c1_prev_q & ~lvl[cluster_pkg::CTL_CLK1])
                                  : (~c1_prev_q & lvl[cluster_pkg::CTL_CLK1]);
  assign edge2 = src_q[`SRC_POL2] ? (c2_prev_q & ~lvl[cluster_pkg::CTL_CLK2])
                                  : (~c2_prev_q & lvl[cluster_pkg::CTL_CLK2]);
  assign gate1_eff = sload_on | !used(src_q, cluster_pkg::CTL_GATE1) |
                     lvl[cluster_pkg::CTL_GATE1];
  assign gate2_eff = !used(src_q, cluster_pkg::CTL_GATE2) | lvl[cluster_pkg::CTL_GATE2];

  cluster_ctrl_if ctl ();

  assign ctl.tick1    = edge1 & gate1_eff;
  assign ctl.tick2    = edge2 & gate2_eff;
  assign ctl.aclr1    = lvl[cluster_pkg::CTL_ACLR1];
  assign ctl.aclr2    = lvl[cluster_pkg::CTL_ACLR2];
  assign ctl.sclr     = lvl[cluster_pkg::CTL_SCLR];
  assign ctl.sload    = lvl[cluster_pkg::CTL_SLOAD];
  assign ctl.chip_clr = CHIP_CLEAR_EN & ~i_chip_wide_clear_n;

  // ****************************************
  // cells, carry and register chains
  // ****************************************
  logic [16:0] carry;
  logic [16:0] chain;

  assign carry[0] = i_carry_in;
  assign chain[0] = 1'b0;

  for (genvar g = 0; g < 16; g++) begin : g_cell
    logic reg_out;
    logic_cell_slice u_cell (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_ce    (i_ce),
      .ctl     (ctl),
      .i_cfg   (cfg_q[g]),
      .i_data  (i_cell_data[g*4 +: 4]),
      .i_carry (carry[g]),
      .i_chain (chain[g]),
      .o_comb  (o_comb[g]),
      .o_reg   (reg_out),
      .o_carry (carry[g+1])
    );
    assign o_reg[g]   = reg_out;
    assign chain[g+1] = reg_out;
  end

  assign o_carry_out = carry[16];

  // ****************************************
  // checks
  // ****************************************
  sequence bus_asked;
    req && !ack_q && i_ce;
  endsequence

  sequence bus_done;
    !o_avs_waitrequest ##1 !ack_q;
  endsequence

  bus_answer_a: assert property (@(posedge i_clk) disable iff (i_reset)
    bus_asked ##1 i_ce |-> bus_done) else $error("bus answer not in one cycle");
  on_limit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    n_on <= `MAX_ON) else $error("more than seven controls in use");
  local_limit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    n_local <= `MAX_LOCAL) else $error("more than four local controls");
  gate_sload_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !(sload_on && used(src_q, cluster_pkg::CTL_GATE1)))
    else $error("first gate used with sync load");
  pack_sload_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !(sload_on && any_pack)) else $error("packing with sync load");
  gate_stop_a: assert property (@(posedge i_clk) disable iff (i_reset)
    used(src_q, cluster_pkg::CTL_GATE1) && !sload_on && !lvl[cluster_pkg::CTL_GATE1] |-> !ctl.tick1)
    else $error("gated clock still ticks");
  fall_edge_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctl.tick2 && src_q[`SRC_POL2] |-> c2_prev_q && !lvl[cluster_pkg::CTL_CLK2])
    else $error("falling clock ticked on rise");
  err_sticky_a: assert property (@(posedge i_clk) disable iff (i_reset)
    err_q[`ST_LOCAL] && !wr_go |=> err_q[`ST_LOCAL]) else $error("error flag lost");
  refuse_src_a: assert property (@(posedge i_clk) disable iff (i_reset)
    err_set[`ST_LOCAL] |=> src_q == $past(src_q)) else $error("bad setup stored");
endmodule : logic_cluster_core

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic        i_clk;
  logic        i_reset;
  logic        i_ce;
  logic [6:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [5:0]  i_row_clk;
  logic [7:0]  i_local_ctrl;
  logic [63:0] i_cell_data;
  logic        i_carry_in;
  logic        i_chip_wide_clear_n;
  logic [15:0] o_comb;
  logic [15:0] o_reg;
  logic        o_carry_out;
  logic [38:0] exp_q[$];
  logic [15:0] mask_a[16];
  logic [15:0] e_v;
  logic [16:0] sum_v;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [63:0] cd;
  logic [3:0]  idx;
  int          n_fail;
  int          n_tests;
  int          seed;

  logic_cluster_core #(.CHIP_CLEAR_EN(1'b1)) u_logic_cluster_core (
    .i_clk               (i_clk),
    .i_reset             (i_reset),
    .i_ce                (i_ce),
    .i_avs_address       (i_avs_address),
    .i_avs_read          (i_avs_read),
    .i_avs_write         (i_avs_write),
    .i_avs_writedata     (i_avs_writedata),
    .i_avs_byteenable    (i_avs_byteenable),
    .o_avs_readdata      (o_avs_readdata),
    .o_avs_waitrequest   (o_avs_waitrequest),
    .i_row_clk           (i_row_clk),
    .i_local_ctrl        (i_local_ctrl),
    .i_cell_data         (i_cell_data),
    .i_carry_in          (i_carry_in),
    .i_chip_wide_clear_n (i_chip_wide_clear_n),
    .o_comb              (o_comb),
    .o_reg               (o_reg),
    .o_carry_out         (o_carry_out)
  );

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
    end
  endtask : chk

  // read data is taken at the edge where the read is accepted
  always @(posedge i_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[FAIL] readdata expected a noted value seen %h", o_avs_readdata);
      end else begin
        chk($sformatf("readdata_%h", exp_q[0][38:32]), o_avs_readdata, exp_q[0][31:0]);
        void'(exp_q.pop_front());
      end
    end
  end

  task automatic xfer(input logic wr, input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    i_avs_address    <= a;
    i_avs_writedata  <= d;
    i_avs_byteenable <= be;
    i_avs_write      <= wr;
    i_avs_read       <= !wr;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0 && k < 40) begin
      @(posedge i_clk);
      k++;
    end
    if (o_avs_waitrequest !== 1'b0) begin
      n_fail++;
      test_done();
    end
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    @(posedge i_clk);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    exp_q.push_back({a, e});
    xfer(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  task automatic cfg_all(input logic [31:0] c);
    for (int g = 0; g < 16; g++) begin
      wr(7'h40 + 7'(4 * g), c);
    end
  endtask : cfg_all

  // one rising then one falling edge on a row clock line
  task tick(input int b);
    i_row_clk[b] <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_row_clk[b] <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : tick

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed                = 32'h9AB9;
    n_fail              = 0;
    n_tests             = 0;
    i_reset             = 1'b1;
    i_ce                = 1'b1;
    i_avs_address       = 7'h00;
    i_avs_read          = 1'b0;
    i_avs_write         = 1'b0;
    i_avs_writedata     = 32'h0;
    i_avs_byteenable    = 4'hF;
    i_row_clk           = 6'h00;
    i_local_ctrl        = 8'h00;
    i_cell_data         = 64'h0;
    i_carry_in          = 1'b0;
    i_chip_wide_clear_n = 1'b1;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(7'h00, 32'h00FF_FFFF);
    rd(7'h04, 32'h0000_0000);
    rd(7'h08, 32'h0000_0000);
    rd(7'h40, 32'h0000_0000);
    rd(7'h0C, 32'h0000_0000);
    // normal mode table lookup, odd cells take carry as the fourth input
    xfer(1'b1, 7'h00, 32'h0000_00F8, 4'h1);
    rd(7'h00, 32'h00FF_FFF8);
    i_cell_data <= {$random(seed), $random(seed)};
    i_carry_in  <= 1'b1;
    for (int g = 0; g < 16; g++) begin
      mask_a[g] = 16'($random(seed));
      wr(7'h40 + 7'(4 * g), {14'h0, g[0], 1'b0, mask_a[g]});
    end
    tick(0);
    for (int g = 0; g < 16; g++) begin
      idx = {g[0] ? i_carry_in : i_cell_data[4*g+3], i_cell_data[4*g+2], i_cell_data[4*g+1], i_cell_data[4*g]};
      e_v[g] = mask_a[g][idx];
    end
    rd(7'h08, {15'h0, 1'b1, e_v});
    rd(7'h04, 32'h0000_0100);
    // sixteen-bit add across the carry chain
    op_a = 16'($random(seed));
    op_b = 16'($random(seed));
    cd = 64'h0;
    for (int g = 0; g < 16; g++) begin
      cd[4*g +: 2] = {op_b[g], op_a[g]};
    end
    i_cell_data <= cd;
    i_carry_in  <= 1'($random(seed));
    cfg_all(32'h0001_9696);
    sum_v = {1'b0, op_a} + {1'b0, op_b} + {16'h0, i_carry_in};
    chk("comb", {16'h0, o_comb}, {16'h0, sum_v[15:0]});
    tick(0);
    rd(7'h08, {15'h0, sum_v});
    cfg_all(32'h0040_0000);
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, sum_v[14:0], 1'b0});
    // control limits refuse the write
    wr(7'h00, 32'h0);
    rd(7'h00, 32'h00FF_FFF8);
    rd(7'h04, 32'h0000_0105);
    wr(7'h04, 32'h0000_000F);
    wr(7'h00, 32'h00FF_EDB6);
    rd(7'h04, 32'h0000_0102);
    wr(7'h04, 32'h0000_000F);
    wr(7'h00, 32'h005F_FEF8);
    rd(7'h04, 32'h0000_0104);
    wr(7'h04, 32'h0000_000F);
    // synchronous clear from the local interconnect
    wr(7'h00, 32'h00FB_FFF8);
    i_local_ctrl <= 8'h40;
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'h0});
    rd(7'h04, 32'h0000_1200);
    i_local_ctrl <= 8'h00;
    // synchronous load, then packing is refused
    wr(7'h00, 32'h005F_FFF8);
    cd = {$random(seed), $random(seed)};
    i_row_clk[2] <= 1'b1;
    i_cell_data  <= cd;
    @(posedge i_clk);
    tick(0);
    for (int g = 0; g < 16; g++) begin
      e_v[g] = cd[4*g+3];
    end
    rd(7'h08, {15'h0, i_carry_in, e_v});
    wr(7'h40, 32'h0080_0000);
    rd(7'h40, 32'h0040_0000);
    rd(7'h04, 32'h0000_0208);
    i_row_clk[2] <= 1'b0;
    wr(7'h04, 32'h0000_000F);
    // clock gate one stops clock one
    wr(7'h00, 32'h00FF_FEF8);
    cfg_all(32'h0000_FFFF);
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, e_v});
    i_row_clk[3] <= 1'b1;
    @(posedge i_clk);
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    i_row_clk[3] <= 1'b0;
    // clock two on the falling edge only
    wr(7'h00, 32'h02FF_FFE8);
    cfg_all(32'h0004_0000);
    i_row_clk[5] <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    i_row_clk[5] <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd(7'h08, {15'h0, i_carry_in, 16'h0000});
    // storage kinds D, T, JK, SR by cell index
    wr(7'h00, 32'h00FF_FFF8);
    i_cell_data <= 64'h0;
    for (int g = 0; g < 16; g++) begin
      wr(7'h40 + 7'(4 * g), {5'h0, 2'(g % 4), 9'h0, 16'hFFFF});
    end
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    i_cell_data <= 64'h0800_0800_0800_0800;
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'h9999});
    // asynchronous clear, preset cells and chip-wide clear
    wr(7'h00, 32'h00FF_CFF8);
    for (int g = 0; g < 16; g++) begin
      wr(7'h40 + 7'(4 * g), (g < 8) ? 32'h0010_FFFF : 32'h0030_FFFF);
    end
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    i_row_clk[4] <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(7'h08, {15'h0, i_carry_in, 16'hFF00});
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFF00});
    i_row_clk[4] <= 1'b0;
    @(posedge i_clk);
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    i_chip_wide_clear_n <= 1'b0;
    @(posedge i_clk);
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFF00});
    i_chip_wide_clear_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    // register feedback toggles on each clock one event; a low clock enable freezes it
    cfg_all(32'h0100_5555);
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    i_ce <= 1'b0;
    tick(0);
    i_ce <= 1'b1;
    @(posedge i_clk);
    rd(7'h08, {15'h0, i_carry_in, 16'hFFFF});
    tick(0);
    rd(7'h08, {15'h0, i_carry_in, 16'h0000});
    test_done();
  end
endmodule : testbench
